// *** include/nioc_cfg.svh ***
// Constants for the neutral instantaneous overcurrent block
//--------------------------------------------------------------
// Behaviour
// RL1: Two identical elements, own settings and outputs
// RL2: Function picks one of six; disabled never operates
// RL3: Aux mask relays 3-7 driven on operate
// RL4: Pickup 0.05-20.00 xCT versus neutral current
// RL5: Definite delay 0.00-600.00 s, 0.01 s steps
// RL6: Forward/reverse setting needs matching directional decision
// RL7: Directional operates on calculated neutral current
// RL8: Voltage reference is minus one third voltage sum
// RL9: Low polarizing voltage defaults direction to forward
// RL10: Current polarized: forward within 90 degrees
// RL11: Polarizing current below 5 percent means forward
// RL12: Dual mode falls back; both insufficient means forward
// RL13: Dual with both valid: both must agree
// RL14: Polarizing mode voltage, current or dual; voltage default
// RL15: Torque angle 0-359, default 315, voltage only
// RL16: Minimum polarizing voltage 0.00-1.25, default 0.05
// RL17: Directional function and own aux relay mask
// RL18: Directional decision gates every directional element
// RL19: Elements blockable singly or as a group
// RL20: Timer runs while all conditions hold, clears otherwise
//--------------------------------------------------------------
`ifndef NIOC_CFG_SVH
`define NIOC_CFG_SVH

// Register byte offsets
`define NIOC_OFS_EL_BASE 6'h00
`define NIOC_EL_STRIDE 6'h0C
`define NIOC_SUB_CFG 6'h00
`define NIOC_SUB_PICK 6'h04
`define NIOC_SUB_DLY 6'h08
`define NIOC_OFS_DIR_CFG 6'h18
`define NIOC_OFS_DIR_MTA 6'h1C
`define NIOC_OFS_DIR_MINV 6'h20
`define NIOC_OFS_STATUS 6'h24
`define NIOC_OFS_CLEAR 6'h28

// Field positions
`define NIOC_F_FUNC 2:0
`define NIOC_F_DIR 5:4
`define NIOC_F_DFUNC 1:0
`define NIOC_F_POL 3:2
`define NIOC_F_AUX 12:8
`define NIOC_F_PICK 10:0
`define NIOC_F_DLY 15:0
`define NIOC_F_MTA 8:0
`define NIOC_F_MINV 6:0

// Reset values
`define NIOC_RST_PICK 11'h064
`define NIOC_RST_DLY 16'h0000
`define NIOC_RST_MTA 9'h13B
`define NIOC_RST_MINV 7'h05

// Polarizing current floor, 0.05 x CT in 0.01 units
`define NIOC_IPOL_MIN 16'h0005

// Angles in degrees
`define NIOC_DEG_90 10'h05A
`define NIOC_DEG_180 9'h0B4
`define NIOC_DEG_270 10'h10E
`define NIOC_DEG_360 10'h168

// Timing: delay step and clock period
`define NIOC_TICK_NS 10000000
`define NIOC_CLK_NS 8

`endif

// *** include/nioc_pkg.sv ***
// Types for the neutral instantaneous overcurrent block
package nioc_pkg;

	// Element function selection
	typedef enum logic [2:0] {
		NIOC_F_DIS, NIOC_F_TRIP, NIOC_F_TRIPRC,
		NIOC_F_ALARM, NIOC_F_LATCH, NIOC_F_CTRL
	} nioc_func_e;

	// Directional unit function selection
	typedef enum logic [1:0] {
		NIOC_DF_DIS, NIOC_DF_ALARM, NIOC_DF_LATCH, NIOC_DF_CTRL
	} nioc_dfunc_e;

	// Element direction setting
	typedef enum logic [1:0] {NIOC_D_OFF, NIOC_D_FWD, NIOC_D_REV} nioc_dir_e;

	// Polarizing mode
	typedef enum logic [1:0] {NIOC_P_VOLT, NIOC_P_CURR, NIOC_P_DUAL} nioc_pol_e;

	// Phasor: magnitude in 0.01 units of nominal, angle 0..359 degrees
	typedef struct packed {
		logic [15:0] mag;
		logic [8:0] ang;
	} nioc_phasor_s;

	// Measurement bundle from the phasor front end
	typedef struct packed {
		nioc_phasor_s neut;
		nioc_phasor_s vsum;
		nioc_phasor_s gnd;
	} nioc_meas_s;

endpackage

// *** src/nioc_top.sv ***
// Two neutral instantaneous elements under a neutral directional unit
`timescale 1ns/1ns
`default_nettype none
`include "nioc_cfg.svh"

module nioc_top #(
	parameter int TICK_CYC = `NIOC_TICK_NS / `NIOC_CLK_NS
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire nioc_pkg::nioc_meas_s meas,
	input wire logic [1:0] blk_el,
	input wire logic blk_all,
	output logic [1:0] el_op,
	output logic trip,
	output logic trip_with_reclose,
	output logic alarm,
	output logic control,
	output logic [4:0] aux_relay,
	output logic dir_reverse
);
	import nioc_pkg::*;

	localparam int PRE_W = $clog2(TICK_CYC + 1);

	//----------------------------------------------------------
	// Helper functions
	//----------------------------------------------------------

	// Angle sum modulo 360
	function automatic logic [8:0] ang_add(input logic [8:0] a,
		input logic [8:0] b);
		logic [9:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= `NIOC_DEG_360) begin
			s = s - `NIOC_DEG_360;
		end
		return s[8:0];
	endfunction

	// True when op lies within plus or minus 90 degrees of ref
	function automatic logic ang_fwd(input logic [8:0] op,
		input logic [8:0] refa);
		logic [9:0] d;
		d = {1'b0, op} + `NIOC_DEG_360 - {1'b0, refa};
		if (d >= `NIOC_DEG_360) begin
			d = d - `NIOC_DEG_360;
		end
		return (d <= `NIOC_DEG_90) || (d >= `NIOC_DEG_270);
	endfunction

	// Address match for element register i, sub offset sub
	function automatic logic el_hit(input logic [5:0] a, input int i,
		input logic [5:0] sub);
		return a == 6'(`NIOC_OFS_EL_BASE + i * `NIOC_EL_STRIDE + sub);
	endfunction

	//----------------------------------------------------------
	// Settings storage
	//----------------------------------------------------------
	nioc_func_e el_func_r [2]; // Element function
	nioc_dir_e el_dir_r [2]; // Element direction
	logic [4:0] el_aux_r [2]; // Aux relays 3..7, bit 0 is relay 3
	logic [10:0] el_pick_r [2]; // Pickup, 0.01 x CT
	logic [15:0] el_dly_r [2]; // Delay, 0.01 s steps
	nioc_dfunc_e dir_func_r; // Directional function
	nioc_pol_e dir_pol_r; // Polarizing mode
	logic [4:0] dir_aux_r; // Directional aux relays
	logic [8:0] dir_mta_r; // Max torque angle, degrees lead
	logic [6:0] dir_minv_r; // Min polarizing voltage, 0.01 x VT
	logic [2:0] lat_r; // Latched alarms: el1, el2, directional
	logic [1:0] el_op_r; // Element operate
	logic ack_r; // Second cycle of a bus access
	logic [31:0] rdata_r; // Read data
	logic [2:0] blk_s1_r; // Block pins, first sync stage
	logic [2:0] blk_s2_r; // Block pins, second sync stage

	//----------------------------------------------------------
	// Avalon slave: every access takes one wait cycle
	//----------------------------------------------------------
	logic bus_req; // Read or write pending
	logic wr_go; // Write commits this edge
	assign bus_req = avs_read | avs_write;
	assign wr_go = avs_write & ack_r;
	assign avs_waitrequest = bus_req & ~ack_r;
	assign avs_readdata = rdata_r;

	// Wait state tracker; drops after the committing edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req & ~ack_r;
		end
	end

	// Element settings; bad codes fall back to safe values [RL1]
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				el_func_r[i] <= NIOC_F_DIS;
				el_dir_r[i] <= NIOC_D_OFF;
				el_aux_r[i] <= 5'h00;
				el_pick_r[i] <= `NIOC_RST_PICK;
				el_dly_r[i] <= `NIOC_RST_DLY;
			end
		end else if (wr_go) begin
			for (int i = 0; i < 2; i++) begin
				// Config word: function, direction, aux mask [RL2] [RL3] [RL6]
				if (el_hit(avs_address, i, `NIOC_SUB_CFG)) begin
					el_func_r[i] <= (avs_writedata[`NIOC_F_FUNC] > 3'h5) ?
						NIOC_F_DIS : nioc_func_e'(avs_writedata[`NIOC_F_FUNC]);
					el_dir_r[i] <= (avs_writedata[`NIOC_F_DIR] == 2'h3) ?
						NIOC_D_OFF : nioc_dir_e'(avs_writedata[`NIOC_F_DIR]);
					el_aux_r[i] <= avs_writedata[`NIOC_F_AUX];
				end
				// Pickup word, range kept by firmware [RL4]
				if (el_hit(avs_address, i, `NIOC_SUB_PICK)) begin
					el_pick_r[i] <= avs_writedata[`NIOC_F_PICK];
				end
				// Delay word [RL5]
				if (el_hit(avs_address, i, `NIOC_SUB_DLY)) begin
					el_dly_r[i] <= avs_writedata[`NIOC_F_DLY];
				end
			end
		end
	end

	// Directional settings [RL14] [RL15] [RL16] [RL17]
	always_ff @(posedge mclk) begin
		if (rst) begin
			dir_func_r <= NIOC_DF_DIS;
			dir_pol_r <= NIOC_P_VOLT;
			dir_aux_r <= 5'h00;
			dir_mta_r <= `NIOC_RST_MTA;
			dir_minv_r <= `NIOC_RST_MINV;
		end else if (wr_go) begin
			case (avs_address)
				`NIOC_OFS_DIR_CFG: begin
					dir_func_r <= nioc_dfunc_e'(avs_writedata[`NIOC_F_DFUNC]);
					dir_pol_r <= (avs_writedata[`NIOC_F_POL] == 2'h3) ?
						NIOC_P_VOLT : nioc_pol_e'(avs_writedata[`NIOC_F_POL]);
					dir_aux_r <= avs_writedata[`NIOC_F_AUX];
				end
				// Angles above 359 are folded back to keep arithmetic sane
				`NIOC_OFS_DIR_MTA: begin
					dir_mta_r <= ang_add(avs_writedata[`NIOC_F_MTA], 9'h000);
				end
				`NIOC_OFS_DIR_MINV: begin
					dir_minv_r <= avs_writedata[`NIOC_F_MINV];
				end
				default: begin
				end
			endcase
		end
	end

	//----------------------------------------------------------
	// Block inputs: pins from outside, two-stage synchroniser
	//----------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			blk_s1_r <= 3'h0;
			blk_s2_r <= 3'h0;
		end else begin
			blk_s1_r <= {blk_all, blk_el};
			blk_s2_r <= blk_s1_r;
		end
	end

	//----------------------------------------------------------
	// Directional unit
	//----------------------------------------------------------
	logic [15:0] vpol_mag; // Polarizing voltage, 0.01 x VT
	logic [8:0] vref_ang; // Reference angle including torque angle
	logic v_ok, i_ok; // Polarizing quantities adequate
	logic v_fwd, i_fwd; // Voltage and current polarized forward decisions
	logic fwd_ok, rev_ok; // Forward and reverse permission

	// Minus V0: magnitude over three, angle turned by 180 [RL8]
	assign vpol_mag = meas.vsum.mag / 16'd3;
	// Operating current leads reference by the torque angle [RL15]
	assign vref_ang = ang_add(ang_add(meas.vsum.ang, `NIOC_DEG_180),
		dir_mta_r);
	assign v_ok = vpol_mag >= {9'h000, dir_minv_r}; // [RL16]
	assign i_ok = meas.gnd.mag >= `NIOC_IPOL_MIN; // [RL11]
	// Neutral current is the operating quantity for both [RL7]
	assign v_fwd = ang_fwd(meas.neut.ang, vref_ang);
	assign i_fwd = ang_fwd(meas.neut.ang, meas.gnd.ang); // [RL10]

	// Mode resolution; inadequate polarizing defaults to forward
	always_comb begin
		fwd_ok = 1'b1;
		rev_ok = 1'b0;
		case (dir_pol_r)
			NIOC_P_VOLT: begin
				if (v_ok) begin
					fwd_ok = v_fwd;
					rev_ok = ~v_fwd;
				end // [RL9]
			end
			NIOC_P_CURR: begin
				if (i_ok) begin
					fwd_ok = i_fwd;
					rev_ok = ~i_fwd;
				end // [RL11]
			end
			NIOC_P_DUAL: begin
				if (v_ok && i_ok) begin
					// Either one may block; both must agree [RL13]
					fwd_ok = v_fwd & i_fwd;
					rev_ok = ~v_fwd & ~i_fwd;
				end else if (v_ok) begin
					fwd_ok = v_fwd;
					rev_ok = ~v_fwd;
				end else if (i_ok) begin
					fwd_ok = i_fwd;
					rev_ok = ~i_fwd;
				end // [RL12]
			end
			default: begin
			end
		endcase
	end

	//----------------------------------------------------------
	// Elements: pickup, direction gate, definite timer
	//----------------------------------------------------------
	logic [1:0] el_run; // All operate conditions met
	logic [PRE_W-1:0] pre_r [2]; // Cycles within one delay step
	logic [15:0] cnt_r [2]; // Elapsed delay steps

	// Conditions for each element [RL2] [RL4] [RL6] [RL18] [RL19]
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			el_run[i] = (el_func_r[i] != NIOC_F_DIS)
				&& !blk_s2_r[i] && !blk_s2_r[2]
				&& (meas.neut.mag >= {5'h00, el_pick_r[i]})
				&& ((el_dir_r[i] == NIOC_D_OFF)
				|| (el_dir_r[i] == NIOC_D_FWD && fwd_ok)
				|| (el_dir_r[i] == NIOC_D_REV && rev_ok));
		end
	end

	// Timer restarts from zero whenever a condition drops [RL20]
	// Prescaler is per element so a step is never cut short [RL5]
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 2; i++) begin
			if (rst || !el_run[i]) begin
				pre_r[i] <= '0;
				cnt_r[i] <= 16'h0000;
				el_op_r[i] <= 1'b0;
			end else if (cnt_r[i] >= el_dly_r[i]) begin
				el_op_r[i] <= 1'b1;
			end else if (pre_r[i] == PRE_W'(TICK_CYC - 1)) begin
				pre_r[i] <= '0;
				cnt_r[i] <= cnt_r[i] + 16'h0001;
			end else begin
				pre_r[i] <= pre_r[i] + PRE_W'(1);
			end
		end
	end
	assign el_op = el_op_r;

	//----------------------------------------------------------
	// Latched alarms and output relays
	//----------------------------------------------------------
	logic dir_act; // Directional unit operating on reverse

	assign dir_act = (dir_func_r != NIOC_DF_DIS) & rev_ok; // [RL17]

	// Latches: a new event wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			lat_r <= 3'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (el_op_r[i] && el_func_r[i] == NIOC_F_LATCH) begin
					lat_r[i] <= 1'b1;
				end else if (wr_go && avs_address == `NIOC_OFS_CLEAR
					&& avs_writedata[i]) begin
					lat_r[i] <= 1'b0;
				end
			end
			if (dir_act && dir_func_r == NIOC_DF_LATCH) begin
				lat_r[2] <= 1'b1;
			end else if (wr_go && avs_address == `NIOC_OFS_CLEAR
				&& avs_writedata[2]) begin
				lat_r[2] <= 1'b0;
			end
		end
	end

	// Output relays, registered one cycle behind operate [RL2] [RL3]
	always_ff @(posedge mclk) begin
		if (rst) begin
			trip <= 1'b0;
			trip_with_reclose <= 1'b0;
			alarm <= 1'b0;
			control <= 1'b0;
			aux_relay <= 5'h00;
			dir_reverse <= 1'b0;
		end else begin
			trip <= 1'b0;
			trip_with_reclose <= 1'b0;
			alarm <= (|lat_r) | (dir_act && dir_func_r == NIOC_DF_ALARM);
			control <= dir_act && dir_func_r == NIOC_DF_CTRL;
			aux_relay <= dir_act ? dir_aux_r : 5'h00;
			dir_reverse <= rev_ok;
			for (int i = 0; i < 2; i++) begin
				if (el_op_r[i]) begin
					case (el_func_r[i])
						NIOC_F_TRIP: trip <= 1'b1;
						NIOC_F_TRIPRC: begin
							trip <= 1'b1;
							trip_with_reclose <= 1'b1;
						end
						NIOC_F_ALARM: alarm <= 1'b1;
						NIOC_F_LATCH: alarm <= 1'b1;
						NIOC_F_CTRL: control <= 1'b1;
						default: begin
						end
					endcase
				end
			end
			// Aux masks merged across elements and directional unit
			aux_relay <= (dir_act ? dir_aux_r : 5'h00)
				| (el_op_r[0] ? el_aux_r[0] : 5'h00)
				| (el_op_r[1] ? el_aux_r[1] : 5'h00); // [RL3]
		end
	end

	//----------------------------------------------------------
	// Read data, captured on the first cycle of a read
	//----------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read && !ack_r) begin
			rdata_r <= 32'h0000_0000;
			for (int i = 0; i < 2; i++) begin
				if (el_hit(avs_address, i, `NIOC_SUB_CFG)) begin
					rdata_r <= {19'h00000, el_aux_r[i], 2'h0, el_dir_r[i],
						1'b0, el_func_r[i]};
				end
				if (el_hit(avs_address, i, `NIOC_SUB_PICK)) begin
					rdata_r <= {21'h000000, el_pick_r[i]};
				end
				if (el_hit(avs_address, i, `NIOC_SUB_DLY)) begin
					rdata_r <= {16'h0000, el_dly_r[i]};
				end
			end
			case (avs_address)
				`NIOC_OFS_DIR_CFG: rdata_r <= {19'h00000, dir_aux_r, 4'h0,
					dir_pol_r, dir_func_r};
				`NIOC_OFS_DIR_MTA: rdata_r <= {23'h000000, dir_mta_r};
				`NIOC_OFS_DIR_MINV: rdata_r <= {25'h0000000, dir_minv_r};
				// Live state: operate, run, direction, polarizing, latches
				`NIOC_OFS_STATUS: rdata_r <= {21'h000000, lat_r, i_ok,
					v_ok, rev_ok, fwd_ok, el_run, el_op_r};
				default: begin
				end
			endcase
		end
	end

	//----------------------------------------------------------
	// Checks
	//----------------------------------------------------------
	a_disabled_no_op: assert property (@(posedge mclk) disable iff (rst) // [RL2]
		el_func_r[0] == NIOC_F_DIS |=> !el_op_r[0])
		else $error("disabled element operated");
	a_zero_delay_op: assert property (@(posedge mclk) disable iff (rst) // [RL5]
		el_run[1] && el_dly_r[1] == 16'h0000 && cnt_r[1] == 16'h0000
		|=> el_run[1] |-> ##1 el_op_r[1])
		else $error("zero delay did not operate");
	a_drop_clears: assert property (@(posedge mclk) disable iff (rst) // [RL20]
		!el_run[0] |=> !el_op_r[0] && cnt_r[0] == 16'h0000)
		else $error("timer not cleared on drop");
	a_group_block: assert property (@(posedge mclk) disable iff (rst) // [RL19]
		blk_all ##2 blk_all |=> el_op_r == 2'b00)
		else $error("group block ignored");
	a_vpol_low_fwd: assert property (@(posedge mclk) disable iff (rst) // [RL9]
		dir_pol_r == NIOC_P_VOLT && vpol_mag < {9'h000, dir_minv_r}
		|-> fwd_ok && !rev_ok)
		else $error("low voltage not forward");
	a_dual_agree: assert property (@(posedge mclk) disable iff (rst) // [RL13]
		dir_pol_r == NIOC_P_DUAL && v_ok && i_ok && (fwd_ok || rev_ok)
		|-> v_fwd == i_fwd)
		else $error("dual decision without agreement");
	a_dir_gate: assert property (@(posedge mclk) disable iff (rst) // [RL6]
		el_op_r[0] && $past(el_dir_r[0]) == NIOC_D_REV |-> $past(rev_ok))
		else $error("operated against direction");
	a_aux_follow: assert property (@(posedge mclk) disable iff (rst) // [RL3]
		el_op_r[1] |=> (aux_relay & $past(el_aux_r[1])) == $past(el_aux_r[1]))
		else $error("aux relays not driven");
	a_bus_one_wait: assert property (@(posedge mclk) disable iff (rst)
		bus_req && !ack_r |=> !avs_waitrequest)
		else $error("bus wait longer than one cycle");

endmodule
`default_nettype wire

// *** verif/neutral_inst_overcurrent_directional_tb.sv ***
// Self-checking bench for the neutral instantaneous overcurrent block
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) \
	begin \
		samples_checked++; \
		if ((got) !== (ex)) begin \
			fail_count++; \
			$display("Error %s expected %0h seen %0h", nm, ex, got); \
		end \
	end

module neutral_inst_overcurrent_directional_tb;
	import nioc_pkg::*;

	// Short tick so delay counts stay brief in simulation
	localparam int TICK = 4;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	nioc_meas_s raw = '0; // Requested phasors
	nioc_meas_s meas; // What the front end delivers
	logic [1:0] blk_el = 2'h0;
	logic blk_all = 1'b0;
	logic [1:0] el_op;
	logic trip;
	logic trip_with_reclose;
	logic alarm;
	logic control;
	logic [4:0] aux_relay;
	logic dir_reverse;
	int fail_count = 0;
	int samples_checked = 0;
	// Reset value table: address and expected word
	logic [5:0] ra [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h18, 6'h1C,
		6'h20, 6'h24, 6'h28, 6'h2C};
	logic [31:0] rv [10] = '{32'h0, 32'h64, 32'h0, 32'h0, 32'h0, 32'h13B,
		32'h5, 32'h10, 32'h0, 32'h0};

	// 125 MHz clock
	always #4 mclk = ~mclk;

	nioc_meas_src u_src (
		.raw(raw),
		.meas(meas)
	);

	nioc_top #(.TICK_CYC(TICK)) u_dut (
		.mclk(mclk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.meas(meas),
		.blk_el(blk_el),
		.blk_all(blk_all),
		.el_op(el_op),
		.trip(trip),
		.trip_with_reclose(trip_with_reclose),
		.alarm(alarm),
		.control(control),
		.aux_relay(aux_relay),
		.dir_reverse(dir_reverse)
	);

	//----------------------------------------------------------
	// Tasks
	//----------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// One Avalon access; an idle edge follows so strobes never double up
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		// Wait for the answer; only the watchdog ends a hung access
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge mclk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask

	// Set a fault, then compare decision, gating and outputs
	// Element 1 trips reverse only, element 2 forward only
	task automatic chk_dir(input logic [1:0] md, input logic [15:0] vm,
		input logic [8:0] va, input logic [15:0] gm, input logic [8:0] na,
		input logic f, input logic r);
		logic [31:0] s;
		bus(1'b1, 6'h18, {19'h0, 5'h10, 4'h0, md, 2'h3}, s);
		raw <= {16'h00C8, na, vm, va, gm, 9'h000};
		tick(4);
		bus(1'b0, 6'h24, 32'h0, s);
		`CHK("direction", {r, f}, s[5:4])
		`CHK("el_op", {f, r}, el_op)
		`CHK("dir_reverse", r, dir_reverse)
		`CHK("control", r, control)
		`CHK("aux_relay", {r, 4'h0}, aux_relay)
	endtask

	// Verdict and end of run
	task automatic results();
		$display("Comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	//----------------------------------------------------------
	// Main sequence
	//----------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [15:0] pk;
		int f;
		tick(12);
		rst <= 1'b0;
		tick(1);
		// Reset values, status and unmapped reads
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, ra[i], 32'h0, q);
			`CHK("reset value", rv[i], q)
		end
		// Refused codes store safe values; angle folded once
		bus(1'b1, 6'h00, 32'h00000037, q);
		bus(1'b0, 6'h00, 32'h0, q);
		`CHK("bad func", 32'h0, q)
		bus(1'b1, 6'h00, 32'hFFFFFF15, q);
		bus(1'b0, 6'h00, 32'h0, q);
		`CHK("el cfg", 32'h00001F15, q)
		bus(1'b1, 6'h18, 32'h0000000C, q);
		bus(1'b0, 6'h18, 32'h0, q);
		`CHK("bad pol", 32'h0, q)
		bus(1'b1, 6'h1C, 32'h00000190, q);
		bus(1'b0, 6'h1C, 32'h0, q);
		`CHK("angle fold", 32'h28, q)
		bus(1'b1, 6'h1C, 32'h0000013B, q);
		bus(1'b1, 6'h08, 32'h0000EA60, q);
		bus(1'b0, 6'h08, 32'h0, q);
		`CHK("max delay", 32'h0000EA60, q)
		bus(1'b1, 6'h08, 32'h0, q);
		// Every function code, with a latched alarm cleared by software
		for (f = 0; f < 6; f++) begin
			bus(1'b1, 6'h00, 32'h1500 | 32'(f), q);
			raw <= {16'h00C8, 59'h0};
			tick(3);
			`CHK("el_op", f != 0, el_op[0])
			`CHK("trip", f == 1 || f == 2, trip)
			`CHK("reclose", f == 2, trip_with_reclose)
			`CHK("alarm", f == 3 || f == 4, alarm)
			`CHK("control", f == 5, control)
			`CHK("aux_relay", f != 0 ? 5'h15 : 5'h00, aux_relay)
			raw <= '0;
			tick(3);
			`CHK("alarm held", f == 4, alarm)
			bus(1'b1, 6'h28, 32'h1, q);
			tick(2);
			`CHK("alarm cleared", 1'b0, alarm)
		end
		// Pickup at both ends of its range
		bus(1'b1, 6'h00, 32'h1, q);
		for (int k = 0; k < 2; k++) begin
			pk = k ? 16'h07D0 : 16'h0005;
			bus(1'b1, 6'h04, {16'h0, pk}, q);
			raw <= {pk - 16'h0001, 59'h0};
			tick(3);
			`CHK("below pickup", 1'b0, el_op[0])
			raw <= {pk + 16'h0001, 59'h0};
			tick(3);
			`CHK("above pickup", 1'b1, el_op[0])
		end
		raw <= '0;
		bus(1'b1, 6'h04, 32'h64, q);
		// Delay of two steps: 2*TICK+1 edges; trip one edge later
		bus(1'b1, 6'h08, 32'h2, q);
		raw <= {16'h00C8, 59'h0};
		tick(9);
		`CHK("el_op early", 1'b0, el_op[0])
		tick(1);
		`CHK("el_op on time", 1'b1, el_op[0])
		`CHK("trip early", 1'b0, trip)
		tick(1);
		`CHK("trip", 1'b1, trip)
		// A dip mid-count restarts the full delay
		raw <= '0;
		tick(2);
		raw <= {16'h00C8, 59'h0};
		tick(5);
		raw <= '0;
		tick(1);
		raw <= {16'h00C8, 59'h0};
		tick(9);
		`CHK("restart early", 1'b0, el_op[0])
		tick(1);
		`CHK("restart on time", 1'b1, el_op[0])
		raw <= '0;
		bus(1'b1, 6'h08, 32'h0, q);
		// Independent elements and blocking
		bus(1'b1, 6'h0C, 32'h3, q);
		bus(1'b1, 6'h10, 32'h96, q);
		raw <= {16'h0078, 59'h0};
		tick(3);
		`CHK("el_op", 2'b01, el_op)
		raw <= {16'h00C8, 59'h0};
		tick(3);
		`CHK("el_op", 2'b11, el_op)
		blk_el <= 2'b01;
		tick(5);
		`CHK("block el1", 2'b10, el_op)
		blk_el <= 2'b10;
		tick(5);
		`CHK("block el2", 2'b01, el_op)
		blk_el <= 2'b00;
		blk_all <= 1'b1;
		tick(5);
		`CHK("block all", 2'b00, el_op)
		blk_all <= 1'b0;
		tick(5);
		`CHK("unblocked", 2'b11, el_op)
		// Directional decisions: angle ref = vsum + 180 + torque angle
		bus(1'b1, 6'h00, 32'h21, q);
		bus(1'b1, 6'h0C, 32'h11, q);
		bus(1'b1, 6'h10, 32'h64, q);
		chk_dir(2'h0, 16'h012C, 9'h000, 16'h0, 9'h0E1, 1'b1, 1'b0);
		chk_dir(2'h0, 16'h012C, 9'h000, 16'h0, 9'h0E2, 1'b0, 1'b1);
		chk_dir(2'h0, 16'h012C, 9'h05A, 16'h0, 9'h02D, 1'b0, 1'b1);
		chk_dir(2'h0, 16'h012C, 9'h05A, 16'h0, 9'h12C, 1'b1, 1'b0);
		chk_dir(2'h0, 16'h000E, 9'h000, 16'h0, 9'h13B, 1'b1, 1'b0);
		chk_dir(2'h0, 16'h000F, 9'h000, 16'h0, 9'h13B, 1'b0, 1'b1);
		chk_dir(2'h1, 16'h012C, 9'h000, 16'h64, 9'h05A, 1'b1, 1'b0);
		chk_dir(2'h1, 16'h012C, 9'h000, 16'h64, 9'h05B, 1'b0, 1'b1);
		chk_dir(2'h1, 16'h012C, 9'h000, 16'h64, 9'h13B, 1'b1, 1'b0);
		chk_dir(2'h1, 16'h012C, 9'h000, 16'h04, 9'h0B4, 1'b1, 1'b0);
		chk_dir(2'h1, 16'h012C, 9'h000, 16'h05, 9'h0B4, 1'b0, 1'b1);
		chk_dir(2'h2, 16'h012C, 9'h000, 16'h64, 9'h087, 1'b0, 1'b0);
		chk_dir(2'h2, 16'h012C, 9'h000, 16'h64, 9'h02D, 1'b1, 1'b0);
		chk_dir(2'h2, 16'h012C, 9'h000, 16'h64, 9'h104, 1'b0, 1'b1);
		chk_dir(2'h2, 16'h000E, 9'h000, 16'h64, 9'h0B4, 1'b0, 1'b1);
		chk_dir(2'h2, 16'h012C, 9'h000, 16'h04, 9'h13B, 1'b0, 1'b1);
		chk_dir(2'h2, 16'h000E, 9'h000, 16'h04, 9'h0B4, 1'b1, 1'b0);
		// Torque angle of zero moves the voltage decision only
		bus(1'b1, 6'h1C, 32'h0, q);
		chk_dir(2'h0, 16'h012C, 9'h000, 16'h0, 9'h0B4, 1'b1, 1'b0);
		chk_dir(2'h0, 16'h012C, 9'h000, 16'h0, 9'h000, 1'b0, 1'b1);
		chk_dir(2'h1, 16'h012C, 9'h000, 16'h64, 9'h05B, 1'b0, 1'b1);
		// Directional alarm follows reverse; latched alarm holds till clear
		bus(1'b1, 6'h1C, 32'h0000013B, q);
		bus(1'b1, 6'h18, 32'h00001001, q);
		raw <= {16'h00C8, 9'h000, 16'h012C, 9'h000, 25'h0};
		tick(4);
		`CHK("dir alarm", 1'b1, alarm)
		bus(1'b1, 6'h18, 32'h00001002, q);
		tick(3);
		raw <= '0;
		tick(4);
		`CHK("dir latch held", 1'b1, alarm)
		bus(1'b0, 6'h24, 32'h0, q);
		`CHK("dir latch bit", 3'h4, q[10:8])
		bus(1'b1, 6'h28, 32'h4, q);
		tick(2);
		`CHK("dir latch cleared", 1'b0, alarm)
		// Reset in mid-run brings every setting back to its default
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(1);
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, ra[i], 32'h0, q);
			`CHK("reset again", rv[i], q)
		end
		results();
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		tick(60000);
		fail_count++;
		$display("Error watchdog expected finish seen timeout");
		results();
	end
endmodule

`default_nettype wire

// *** verif/nioc_meas_src.sv ***
// Model of the phasor front end that feeds the block its measurements
`timescale 1ns/1ns
`default_nettype none

module nioc_meas_src (
	input wire nioc_pkg::nioc_meas_s raw,
	output var nioc_pkg::nioc_meas_s meas
);
	import nioc_pkg::*;

	// Angles arrive folded into 0..359, as the block accepts no more
	function automatic nioc_phasor_s fold(input nioc_phasor_s p);
		nioc_phasor_s q;
		q = p;
		if (q.ang >= 9'h168) begin
			q.ang = q.ang - 9'h168;
		end
		return q;
	endfunction

	// Pass-through: inputs change just after an edge, so meas does too
	always_comb begin
		meas.neut = fold(raw.neut);
		meas.vsum = fold(raw.vsum);
		meas.gnd = fold(raw.gnd);
	end
endmodule

`default_nettype wire
